// ===== hw/rcss_top.sv
// Reset cause recording and start-up sequencing with an AHB-Lite register slave
// Functional notes
// - Both brown-out detectors OR into one reset
// - Low-power detector enabled only by config bit
// - Master clear enabled by LOW_VOLTAGE_PROGRAMMING_ENABLE or enable
// - Enabled master clear held low holds reset
// - Short low pulses on master clear filtered
// - Device never drives master clear pin low
// - Disabled master clear is general input
// - Watchdog timeout and window flags cleared
// - Reset instruction resets, clears its flag
// - Stack faults reset only when enabled
// - Programming exit acts as power-on reset
// - Power-up timer holds reset 64 ms
// - Timer starts after power-on, brown-out release
// - Run waits for timer, oscillator, master clear
// - Timers run regardless of master clear
// - Execution outside valid range raises violation
// - Prefetch alone never raises a violation
// - Violation ignores interrupts, resets, clears flag
// - Only the causing flags change per warm or master clear reset
// - Power-on sets timeout and powerdown bits
// - Interrupt wake sets timeout, clears powerdown
// - Wake with interrupts enabled vectors to 0004h
// - Software writes of flags cause no reset
`timescale 1ns/1ps
module rcss_top
  import rcss_pkg::*;
#(
  parameter int POWERUP_TIMER_CYCLES = RCSS_POWERUP_TIMER_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire rcss_src_s   src,
  input  wire rcss_cfg_s   cfg,
  input  wire logic        ostDone,
  input  wire logic        masterClearPinIn,
  input  wire logic        wakeInterrupt,
  input  wire logic        globalInterruptEnable,
  input  wire logic        sleepWake,
  input  wire logic        gpPullupSw,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             systemReset,
  output logic             cpuRun,
  output logic             interruptBlock,
  output logic             masterClearPinOut,
  output logic             masterClearPinOe,
  output logic             masterClearPullup,
  output logic             gpInput,
  output logic [14:0]      pcLoad,
  output logic             pcLoadValid
);

  logic [9:0]  syncA_ff;
  logic [9:0]  syncB_ff;
  logic [9:0]  syncC_ff;
  logic        mclrA_ff;
  logic        mclrB_ff;
  logic [2:0]  filtCnt_ff;
  logic        mclrLow_ff;
  logic [7:0]  cause0_ff;
  logic [7:0]  cause1_ff;
  logic [1:0]  stat_ff;
  logic [RCSS_CNT_W-1:0] pwrtCnt_ff;
  rcss_state_e state_ff;
  rcss_state_e nxt_state;
  logic        wrPend_ff;
  logic        rdPend_ff;
  logic [7:0]  addr_ff;
  logic        wakePend_ff;
  logic        powerBoot_ff;
  rcss_src_s   syncSrc;
  rcss_src_s   rise;
  logic        mclrEnable;
  logic        brownout;
  logic        powerEvent;
  logic        memViol;
  logic        warmReset;
  logic        anyReset;
  logic        pwrtFinished;

  function automatic logic [31:0] rcss_word(input logic [7:0] v);
    rcss_word = {24'h000000, v};
  endfunction

  // Two flops then an edge register so every flag changes once per event
  always_ff @(posedge core_clk) begin
    if (srst) begin
      syncA_ff <= 10'h000;
      syncB_ff <= 10'h000;
      syncC_ff <= 10'h000;
    end else begin
      syncA_ff <= src;
      syncB_ff <= syncA_ff;
      syncC_ff <= syncB_ff;
    end
  end
  assign syncSrc = syncB_ff;
  assign rise    = syncB_ff & ~syncC_ff;

  assign mclrEnable = cfg.lvpCfg | cfg.mclrCfg;
  assign brownout   = syncSrc.borOut | (syncSrc.lpborOut & cfg.lpborCfg);
  assign powerEvent = syncSrc.por | syncSrc.progExit | brownout;
  assign memViol    = rise.execInvalid;
  assign warmReset  = rise.wdtTimeout | rise.wdtWindow | rise.resetInstr | memViol
                    | (cfg.stvrenCfg & (rise.stack_overflow_flag | rise.stack_underflow_flag));
  assign anyReset   = powerEvent | warmReset | mclrLow_ff;

  // Master clear: synchronise, then require a sustained low level
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mclrA_ff   <= 1'b1;
      mclrB_ff   <= 1'b1;
      filtCnt_ff <= 3'h0;
      mclrLow_ff <= 1'b0;
    end else begin
      mclrA_ff <= masterClearPinIn;
      mclrB_ff <= mclrA_ff;
      if (!mclrEnable || mclrB_ff) begin
        filtCnt_ff <= 3'h0;
        mclrLow_ff <= 1'b0;
      end else if (filtCnt_ff != 3'(RCSS_FILT_CYC)) begin
        filtCnt_ff <= filtCnt_ff + 3'h1;
      end else begin
        mclrLow_ff <= 1'b1;
      end
    end
  end

  // Pin is never driven; pull-up follows mode
  always_ff @(posedge core_clk) begin
    if (srst) begin
      masterClearPinOut <= 1'b1;
      masterClearPinOe  <= 1'b1;
      masterClearPullup <= 1'b1;
      gpInput           <= 1'b0;
    end else begin
      masterClearPinOut <= 1'b1;
      masterClearPinOe  <= 1'b1;
      masterClearPullup <= mclrEnable ? 1'b1 : gpPullupSw;
      gpInput           <= mclrEnable ? 1'b0 : mclrB_ff;
    end
  end

  assign pwrtFinished = cfg.pwrtCfgN || (pwrtCnt_ff == RCSS_CNT_W'(POWERUP_TIMER_CYCLES));

  // Sequencer; the timer ignores master clear entirely
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      RCSS_HOLD: if (!powerEvent) nxt_state = RCSS_POWERUP_TIMER;
      RCSS_POWERUP_TIMER: if (pwrtFinished) nxt_state = RCSS_WAIT;
      RCSS_WAIT: if ((!cfg.ostNeeded || ostDone) && !mclrLow_ff && !warmReset)
                   nxt_state = RCSS_RUN;
      RCSS_RUN:  if (warmReset || mclrLow_ff) nxt_state = RCSS_WAIT;
    endcase
    if (powerEvent) nxt_state = RCSS_HOLD;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_ff   <= RCSS_HOLD;
      pwrtCnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff != RCSS_POWERUP_TIMER || powerEvent) pwrtCnt_ff <= '0;
      else if (!pwrtFinished) pwrtCnt_ff <= pwrtCnt_ff + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      systemReset    <= 1'b1;
      cpuRun         <= 1'b0;
      interruptBlock <= 1'b0;
    end else begin
      systemReset    <= (nxt_state != RCSS_RUN);
      cpuRun         <= (nxt_state == RCSS_RUN);
      interruptBlock <= memViol;
    end
  end

  // Cause flags: hardware events win over software writes in the same cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      powerBoot_ff <= 1'b1;
      cause0_ff    <= RCSS_CAUSE0_POR;
      cause1_ff    <= RCSS_CAUSE1_RST;
      stat_ff      <= RCSS_STAT_RST;
    end else begin
      if (wrPend_ff && addr_ff == RCSS_REG_CAUSE0) cause0_ff <= hwdata[7:0];
      if (wrPend_ff && addr_ff == RCSS_REG_CAUSE1) cause1_ff <= hwdata[7:0] & RCSS_CAUSE1_RST;
      if (wrPend_ff && addr_ff == RCSS_REG_STATUS) stat_ff <= hwdata[1:0];
      if (sleepWake && wakeInterrupt) begin
        stat_ff[RCSS_BIT_TO] <= 1'b1;
        stat_ff[RCSS_BIT_PD] <= 1'b0;
      end
      if (mclrLow_ff && state_ff == RCSS_RUN) cause0_ff[RCSS_BIT_MASTER_CLEAR_PIN] <= 1'b0;
      if (rise.wdtTimeout) begin
        cause0_ff[RCSS_BIT_WDT] <= 1'b0;
        stat_ff[RCSS_BIT_TO]    <= 1'b0;
      end
      if (rise.wdtWindow) cause0_ff[RCSS_BIT_WV] <= 1'b0;
      if (rise.resetInstr) cause0_ff[RCSS_BIT_RI] <= 1'b0;
      if (cfg.stvrenCfg && rise.stack_overflow_flag) cause0_ff[RCSS_BIT_OVF] <= 1'b1;
      if (cfg.stvrenCfg && rise.stack_underflow_flag) cause0_ff[RCSS_BIT_UNF] <= 1'b1;
      if (memViol) cause1_ff[RCSS_BIT_MEMORY_VIOLATION_FLAG] <= 1'b0;
      powerBoot_ff <= powerEvent;
      if (powerEvent && !powerBoot_ff) begin
        if (syncSrc.por || syncSrc.progExit) begin
          cause0_ff <= RCSS_CAUSE0_POR;
          cause1_ff <= RCSS_CAUSE1_RST;
        end else begin
          cause0_ff <= {RCSS_CAUSE0_POR[7:2], cause0_ff[RCSS_BIT_POR], 1'b0};
        end
        stat_ff <= RCSS_STAT_RST;
      end
    end
  end

  // Program counter: interrupt vector after wake, or reset address on start-up
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pcLoad      <= RCSS_PC_RESET;
      pcLoadValid <= 1'b0;
      wakePend_ff <= 1'b0;
    end else begin
      pcLoadValid <= 1'b0;
      wakePend_ff <= 1'b0;
      if (state_ff != RCSS_RUN && nxt_state == RCSS_RUN) begin
        pcLoad      <= RCSS_PC_RESET;
        pcLoadValid <= 1'b1;
      end else if (sleepWake && wakeInterrupt && globalInterruptEnable && !memViol) begin
        wakePend_ff <= 1'b1;
      end else if (wakePend_ff) begin
        pcLoad      <= RCSS_PC_VECTOR;
        pcLoadValid <= 1'b1;
      end
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wrPend_ff <= 1'b0;
      rdPend_ff <= 1'b0;
      addr_ff   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wrPend_ff <= hsel && hready && htrans[1] && hwrite;
      rdPend_ff <= hsel && hready && htrans[1] && !hwrite;
      if (hsel && hready && htrans[1]) addr_ff <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      hrdata <= 32'h00000000;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        RCSS_REG_CAUSE0: hrdata <= rcss_word(cause0_ff);
        RCSS_REG_CAUSE1: hrdata <= rcss_word(cause1_ff);
        RCSS_REG_STATUS: hrdata <= rcss_word({6'h00, stat_ff});
        RCSS_REG_CTRL:   hrdata <= rcss_word({4'h0, state_ff});
        RCSS_REG_PC:     hrdata <= {17'h00000, pcLoad};
        default:         hrdata <= 32'h00000000;
      endcase
    end
  end

  property p_master_clear_pin_hold;
    @(posedge core_clk) disable iff (srst) mclrLow_ff |=> systemReset;
  endproperty
  a_master_clear_pin_hold: assert property (p_master_clear_pin_hold) else $error("reset not held by master clear");

  property p_filter;
    @(posedge core_clk) disable iff (srst) $rose(mclrLow_ff) |-> !mclrB_ff && $past(!mclrB_ff);
  endproperty
  a_filter: assert property (p_filter) else $error("short pulse accepted");

  property p_no_drive;
    @(posedge core_clk) disable iff (srst) ##1 masterClearPinOe;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("master clear driven");

  property p_ri;
    @(posedge core_clk) disable iff (srst) rise.resetInstr && !powerEvent
      |=> !cause0_ff[RCSS_BIT_RI] ##1 systemReset;
  endproperty
  a_ri: assert property (p_ri) else $error("reset instruction flag");

  property p_stk_off;
    @(posedge core_clk) disable iff (srst) !cfg.stvrenCfg && rise.stack_overflow_flag && !powerEvent
      |=> $stable(cause0_ff[RCSS_BIT_OVF]);
  endproperty
  a_stk_off: assert property (p_stk_off) else $error("stack flag changed while disabled");

  property p_powerup_timer;
    @(posedge core_clk) disable iff (srst) state_ff == RCSS_POWERUP_TIMER && !pwrtFinished
      |=> state_ff == RCSS_POWERUP_TIMER || state_ff == RCSS_HOLD;
  endproperty
  a_powerup_timer: assert property (p_powerup_timer) else $error("timer left early");

  property p_start;
    @(posedge core_clk) disable iff (srst) powerEvent |=> state_ff == RCSS_HOLD && pwrtCnt_ff == '0;
  endproperty
  a_start: assert property (p_start) else $error("timer ran before release");

  property p_memory_violation_flag;
    @(posedge core_clk) disable iff (srst) memViol && !powerEvent
      |=> !cause1_ff[RCSS_BIT_MEMORY_VIOLATION_FLAG] && interruptBlock && systemReset;
  endproperty
  a_memory_violation_flag: assert property (p_memory_violation_flag) else $error("memory violation not handled");

  property p_por_stat;
    @(posedge core_clk) disable iff (srst) powerEvent && !powerBoot_ff |=> stat_ff == RCSS_STAT_RST;
  endproperty
  a_por_stat: assert property (p_por_stat) else $error("status bits not set on power event");

  property p_master_clear_pin_off;
    @(posedge core_clk) disable iff (srst) !mclrEnable |=> !mclrLow_ff;
  endproperty
  a_master_clear_pin_off: assert property (p_master_clear_pin_off) else $error("master clear acted while disabled");

  property p_pullup;
    @(posedge core_clk) disable iff (srst) !mclrEnable |=> masterClearPullup == $past(gpPullupSw);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up not under software control");

endmodule

// ===== hw/rcss_pkg.sv
// Package: constants and types for the reset cause and start-up sequencer
package rcss_pkg;
  localparam logic [7:0] RCSS_REG_CAUSE0   = 8'h00;
  localparam logic [7:0] RCSS_REG_CAUSE1   = 8'h04;
  localparam logic [7:0] RCSS_REG_STATUS   = 8'h08;
  localparam logic [7:0] RCSS_REG_CTRL     = 8'h0c;
  localparam logic [7:0] RCSS_REG_PC       = 8'h10;
  localparam int   RCSS_BIT_BOR    = 0;
  localparam int   RCSS_BIT_POR    = 1;
  localparam int   RCSS_BIT_RI     = 2;
  localparam int   RCSS_BIT_MASTER_CLEAR_PIN   = 3;
  localparam int   RCSS_BIT_WDT    = 4;
  localparam int   RCSS_BIT_WV     = 5;
  localparam int   RCSS_BIT_UNF    = 6;
  localparam int   RCSS_BIT_OVF    = 7;
  localparam int   RCSS_BIT_MEMORY_VIOLATION_FLAG   = 1;
  localparam int   RCSS_BIT_TO     = 1;
  localparam int   RCSS_BIT_PD     = 0;
  localparam logic [7:0] RCSS_CAUSE0_POR = 8'h3c;
  localparam logic [7:0] RCSS_CAUSE1_RST = 8'h02;
  localparam logic [1:0] RCSS_STAT_RST   = 2'h3;
  localparam logic [14:0] RCSS_PC_RESET  = 15'h0000;
  localparam logic [14:0] RCSS_PC_VECTOR = 15'h0004;
  localparam int   RCSS_CLK_HZ     = 20000000;
  localparam int   RCSS_POWERUP_TIMER_MS    = 64;
  localparam int   RCSS_POWERUP_TIMER_CYC   = RCSS_CLK_HZ / 1000 * RCSS_POWERUP_TIMER_MS;
  localparam int   RCSS_FILT_CYC   = 4;
  localparam int   RCSS_CNT_W      = 24;

  typedef struct packed {
    logic lpborOut;
    logic borOut;
    logic por;
    logic wdtTimeout;
    logic wdtWindow;
    logic resetInstr;
    logic stack_overflow_flag;
    logic stack_underflow_flag;
    logic progExit;
    logic execInvalid;
  } rcss_src_s;

  typedef struct packed {
    logic lpborCfg;
    logic mclrCfg;
    logic lvpCfg;
    logic pwrtCfgN;
    logic stvrenCfg;
    logic ostNeeded;
  } rcss_cfg_s;

  typedef enum logic [3:0] {
    RCSS_HOLD = 4'b0001,
    RCSS_POWERUP_TIMER = 4'b0010,
    RCSS_WAIT = 4'b0100,
    RCSS_RUN  = 4'b1000
  } rcss_state_e;
endpackage

// ===== test/rcss_partner.sv
// Partner model: external master clear pin driver and oscillator start-up timer
`timescale 1ns/1ps
module rcss_partner #(
  parameter int OST_CYC = 6
) (
  input  wire logic core_clk,
  input  wire logic pinLowReq,
  input  wire logic pinOe,
  input  wire logic pinOut,
  input  wire logic systemReset,
  output logic      pinLevel,
  output logic      ostDone
);
  int cnt = 0;
  // Weak pull-up holds the pin high unless someone pulls it down
  assign pinLevel = pinLowReq ? 1'b0 : (!pinOe ? pinOut : 1'b1);
  // Oscillator settles only while the device sits in reset, so every reset pays for it
  always @(posedge core_clk) begin
    if (!systemReset) begin
      cnt <= 0;
    end else if (cnt < OST_CYC) begin
      cnt <= cnt + 1;
    end
  end
  assign ostDone = (cnt >= OST_CYC);
endmodule

// ===== test/test_reset_cause_and_startup_sequencer.sv
// Self-checking bench for the reset cause and start-up sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module test_reset_cause_and_startup_sequencer;
  import rcss_pkg::*;
  localparam int PW = 20;
  logic        core_clk, srst, ostDone, masterClearPinIn, wakeInterrupt, pinLow;
  logic        globalInterruptEnable, sleepWake, gpPullupSw, hsel, hwrite, hready;
  logic        hreadyout, hresp, systemReset, cpuRun, interruptBlock, pcLoadValid;
  logic        masterClearPinOut, masterClearPinOe, masterClearPullup, gpInput, seen, ib;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [14:0] pcLoad;
  rcss_src_s   src;
  rcss_cfg_s   cfg;
  int          fails = 0, cmp_count = 0, nRun, c0, c1, st, len;
  logic [9:0]  evs[9] = '{10'h040, 10'h020, 10'h010, 10'h008, 10'h004, 10'h008, 10'h200,
                          10'h200, 10'h100};
  int          clr[9] = '{'h10, 'h20, 'h04, 0, 0, 0, 0, 'h01, 'h01};
  int          setb[9] = '{0, 0, 0, 'h80, 'h40, 0, 0, 0, 0};
  assign hready = hreadyout;
  rcss_top #(.POWERUP_TIMER_CYCLES(PW)) DUT (.core_clk, .srst, .src, .cfg, .ostDone, .masterClearPinIn,
    .wakeInterrupt, .globalInterruptEnable, .sleepWake, .gpPullupSw, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .systemReset, .cpuRun,
    .interruptBlock, .masterClearPinOut, .masterClearPinOe, .masterClearPullup, .gpInput,
    .pcLoad, .pcLoadValid);
  rcss_partner #(.OST_CYC(6)) P (.core_clk, .pinLowReq(pinLow), .pinOe(masterClearPinOe),
    .pinOut(masterClearPinOut), .systemReset, .pinLevel(masterClearPinIn), .ostDone);
  initial begin
    core_clk = 0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input int e, input string nm);
    ahb(1'b0, a, 32'h0);
    `CHK(nm, e[31:0], r)
  endtask
  task automatic waitRun();
    nRun = 0;
    while (cpuRun !== 1'b1 && nRun < 400) begin
      @(negedge core_clk);
      nRun++;
    end
    `CHK("cpuRun", 1'b1, cpuRun)
    if (nRun > 0) begin
      `CHK("pc load", 1'b1, pcLoadValid)
      `CHK("reset address", RCSS_PC_RESET, pcLoad)
    end
  endtask
  // Pulse a reset source, note whether reset was taken, then let start-up finish
  task automatic fire(input logic [9:0] s, input logic expRst);
    @(posedge core_clk);
    src <= rcss_src_s'(s);
    repeat (3) @(posedge core_clk);
    src <= '0;
    seen = 0;
    ib = 0;
    repeat (12) begin
      @(negedge core_clk);
      if (systemReset === 1'b1) seen = 1;
      if (interruptBlock === 1'b1) ib = 1;
    end
    `CHK("reset taken", expRst, seen)
    `CHK("interrupt block", s[0], ib)
    // A pin held low keeps the core in reset; the caller releases it and waits
    if (pinLow !== 1'b1) waitRun();
    nRun += 12;
  endtask
  task automatic hold(input int n);
    @(posedge core_clk);
    pinLow <= 1'b1;
    repeat (n) @(posedge core_clk);
    pinLow <= 1'b0;
  endtask
  task automatic done(input string t);
    $display("test %s done", t);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Device must never drive its own master clear pin
  always @(negedge core_clk) if (srst === 1'b0) `CHK("pin enable", 1'b1, masterClearPinOe)
  always @(negedge core_clk) if (srst === 1'b0) `CHK("pin out", 1'b1, masterClearPinOut)
  always @(negedge core_clk) if (srst === 1'b0) `CHK("bus response", 1'b0, hresp)
  initial begin
    #2000000;
    fails++;
    finish_test();
  end
  initial begin
    srst = 1;
    src = '0;
    cfg = '0;
    cfg.ostNeeded = 1;
    cfg.stvrenCfg = 1;
    {pinLow, wakeInterrupt, globalInterruptEnable, sleepWake, gpPullupSw} = '0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    void'($urandom(80));
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    waitRun();
    rd(RCSS_REG_CAUSE0, 'h3c, "cause0");
    rd(RCSS_REG_CAUSE1, 'h02, "cause1");
    rd(RCSS_REG_STATUS, 'h3, "status");
    rd(8'h40, 0, "unmapped");
    done("reset values");
    for (int i = 0; i < 3; i++) begin
      cfg.pwrtCfgN <= (i == 2);
      ahb(1'b1, RCSS_REG_CAUSE0, 32'hff);
      `CHK("no reset on write", 1'b0, systemReset)
      fire(i == 1 ? 10'h002 : 10'h080, 1'b1);
      `CHK("start-up long", i != 2, nRun >= PW)
      rd(RCSS_REG_CAUSE0, 'h3c, "cause0 power-on");
    end
    st = 3;
    done("power-on");
    @(posedge core_clk);
    {wakeInterrupt, sleepWake, globalInterruptEnable} <= 3'h7;
    cfg.pwrtCfgN <= 1'b0;
    @(posedge core_clk);
    {wakeInterrupt, sleepWake} <= 2'h0;
    seen = 0;
    repeat (6) begin
      @(negedge core_clk);
      if (pcLoadValid === 1'b1) `CHK("vector", 15'h0004, pcLoad)
      if (pcLoadValid === 1'b1) seen = 1;
    end
    `CHK("vector load", 1'b1, seen)
    st = st & ~1;
    rd(RCSS_REG_STATUS, st, "status wake");
    done("wake");
    for (int i = 0; i < 9; i++) begin
      @(posedge core_clk);
      cfg.stvrenCfg <= (i != 5);
      cfg.lpborCfg <= (i == 7);
      ahb(1'b1, RCSS_REG_CAUSE0, 32'h3f);
      c0 = ('h3f & ~clr[i]) | setb[i];
      if (i == 0) st = st & ~2;
      if (i >= 7) st = 3;
      fire(evs[i], !(i == 5 || i == 6));
      rd(RCSS_REG_CAUSE0, c0, "cause0 event");
      rd(RCSS_REG_STATUS, st, "status event");
    end
    done("reset sources");
    ahb(1'b1, RCSS_REG_CAUSE1, 32'h2);
    fire(10'h001, 1'b1);
    rd(RCSS_REG_CAUSE1, 0, "cause1 violation");
    done("memory violation");
    @(posedge core_clk);
    cfg.mclrCfg <= 1'b1;
    pinLow <= 1'b1;
    fire(10'h080, 1'b1);
    repeat (60) @(posedge core_clk);
    `CHK("held by pin", 1'b1, systemReset)
    pinLow <= 1'b0;
    waitRun();
    `CHK("timers expired", 1'b1, nRun < PW)
    ahb(1'b1, RCSS_REG_CAUSE0, 32'h3f);
    len = 1 + $urandom % 3;
    hold(len);
    seen = 0;
    repeat (14) begin
      @(negedge core_clk);
      if (systemReset === 1'b1) seen = 1;
    end
    `CHK("glitch ignored", 1'b0, seen)
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      {cfg.lvpCfg, cfg.mclrCfg} <= i[1:0];
      gpPullupSw <= 1'($urandom % 2);
      ahb(1'b1, RCSS_REG_CAUSE0, 32'h3f);
      @(posedge core_clk);
      pinLow <= 1'b1;
      repeat (15) @(negedge core_clk);
      `CHK("pin reset", i != 0, systemReset)
      if (i == 0) `CHK("gp input", 1'b0, gpInput)
      if (i == 0) `CHK("pull-up", gpPullupSw, masterClearPullup)
      @(posedge core_clk);
      pinLow <= 1'b0;
      waitRun();
      rd(RCSS_REG_CAUSE0, i != 0 ? 'h37 : 'h3f, "cause0 pin");
    end
    done("master clear");
    finish_test();
  end
endmodule
